/* File: logic/period_timer_pkg.sv */
// constants for the 8-bit period timer: register offsets, field positions,
// reset values and scaler limits
// assumes an 8-bit register port with byte-wide addresses
package period_timer_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] PERIPHERAL_FLAGS_ADDR = 8'h0C;
  localparam logic [7:0] TIMER_COUNT_ADDR = 8'h11;
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h12;
  localparam logic [7:0] PERIPHERAL_ENABLES_ADDR = 8'h8C;
  localparam logic [7:0] PERIOD_VALUE_ADDR = 8'h92;

  // reset values and the count wrap value
  localparam logic [7:0] TIMER_COUNT_RESET = 8'h00;
  localparam logic [6:0] TIMER_CONTROL_RESET = 7'h00;
  localparam logic [7:0] PERIOD_VALUE_RESET = 8'hFF;
  localparam logic [7:0] COUNT_WRAP_VALUE = 8'h00;

  // control field positions
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_MSB = 1;
  localparam int RUN_BIT = 2;
  localparam int POSTSCALE_LSB = 3;
  localparam int POSTSCALE_MSB = 6;

  // flag / enable field position
  localparam int MATCH_BIT = 1;

  // prescaler terminal counts (ratio minus one)
  localparam logic [3:0] PRESCALE_LIMIT_DIV1 = 4'h0;
  localparam logic [3:0] PRESCALE_LIMIT_DIV4 = 4'h3;
  localparam logic [3:0] PRESCALE_LIMIT_DIV16 = 4'hF;

  // prescale select encodings
  localparam logic [1:0] PRESCALE_SEL_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_SEL_DIV4 = 2'h1;

endpackage : period_timer_pkg

/* File: logic/scaler_counter.sv */
// one 4-bit divide-by-n counter, shared by the prescaler and postscaler
// assumes clear and step come from the same clock domain as mclk
`timescale 1ns/1ps
module scaler_counter
  import period_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic step,
  input wire logic [3:0] limit,
  output logic done,
  output logic [3:0] cnt
);

  logic [3:0] cnt_reg; // running count of steps
  logic [3:0] cnt_next; // next value of the count
  wire at_limit = (cnt_reg == limit); // terminal count reached

  // a clear in the same cycle swallows the step, so no stray pulse escapes
  assign done = step & at_limit & ~clear;
  assign cnt = cnt_reg;

  // next count: clear first, then wrap, then advance
  always_comb
  begin
    cnt_next = cnt_reg;
    if (clear)
      cnt_next = 4'h0;
    else if (step)
      cnt_next = at_limit ? 4'h0 : 4'(cnt_reg + 4'h1);
  end

  // count register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;
  end

endmodule : scaler_counter

/* File: logic/period_timer.sv */
// 8-bit period timer with prescaler, period compare and postscaler
// assumes mclk is the instruction clock and the register port strobes
// are one cycle long, synchronous to mclk, never both at once
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module period_timer
  import period_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic [7:0] timer_count_out,
  output logic match_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] timer_count_reg; // the running count
  logic [7:0] timer_count_next; // its next value
  logic [6:0] timer_control_reg; // control bits 6:0, bit 7 not stored
  logic [7:0] period_value_reg; // period compare value
  logic match_flag_reg; // sticky postscaled match event
  logic match_flag_next; // its next value
  logic match_irq_enable_reg; // mask bit for the match flag
  logic match_pulse_reg; // raw match, one cycle per wrap
  logic [7:0] reg_rdata_reg; // read data, valid one cycle after the strobe

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // an unmapped address selects nothing, so its writes fall away

  wire sel_flags = (reg_addr == PERIPHERAL_FLAGS_ADDR);
  wire sel_count = (reg_addr == TIMER_COUNT_ADDR);
  wire sel_control = (reg_addr == TIMER_CONTROL_ADDR);
  wire sel_enables = (reg_addr == PERIPHERAL_ENABLES_ADDR);
  wire sel_period = (reg_addr == PERIOD_VALUE_ADDR);

  wire wr_flags = reg_wr & sel_flags; // write-one-to-clear strobe
  wire wr_count = reg_wr & sel_count; // count load strobe
  wire wr_control = reg_wr & sel_control; // control load strobe
  wire wr_enables = reg_wr & sel_enables; // mask load strobe
  wire wr_period = reg_wr & sel_period; // period load strobe

  ////////////////////////////////////////////////////////////////////////////
  // control fields
  // bit 7 has no storage at all, so writes to it cannot stick

  wire [1:0] prescale_select = timer_control_reg[PRESCALE_MSB:PRESCALE_LSB];
  wire timer_run = timer_control_reg[RUN_BIT];
  wire [3:0] postscale_select = timer_control_reg[POSTSCALE_MSB:POSTSCALE_LSB];

  // prescale field decode; both 1x codes give sixteen
  wire [3:0] prescale_limit =
    (prescale_select == PRESCALE_SEL_DIV1) ? PRESCALE_LIMIT_DIV1 :
    (prescale_select == PRESCALE_SEL_DIV4) ? PRESCALE_LIMIT_DIV4 :
    PRESCALE_LIMIT_DIV16;

  // postscale ratio is field plus one, so the field is the terminal count
  wire [3:0] postscale_limit = postscale_select;

  // either register write restarts both scalers from zero
  wire scaler_clear = wr_count | wr_control;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler

  wire pre_tick; // one increment cycle of the count
  wire [3:0] pre_cnt; // prescaler count, seen by checks only

  // steps once per instruction clock while running; holding it still
  // while stopped keeps the whole timer quiet
  scaler_counter prescaler_i (
    .mclk(mclk),
    .resetn(resetn),
    .clear(scaler_clear),
    .step(timer_run),
    .limit(prescale_limit),
    .done(pre_tick),
    .cnt(pre_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // count and period compare
  // exact match only: a count loaded above the period runs on to FFh and rolls

  wire count_at_period = (timer_count_reg == period_value_reg);
  wire count_wrap = pre_tick & count_at_period; // match on this increment

  // next count: a software load beats the increment
  always_comb
  begin
    timer_count_next = timer_count_reg;
    if (wr_count)
      timer_count_next = reg_wdata;
    else if (count_wrap)
      timer_count_next = COUNT_WRAP_VALUE;
    else if (pre_tick)
      timer_count_next = 8'(timer_count_reg + 8'h01);
  end

  // count and raw match register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      timer_count_reg <= TIMER_COUNT_RESET;
      match_pulse_reg <= 1'b0;
    end
    else
    begin
      timer_count_reg <= timer_count_next;
      match_pulse_reg <= count_wrap & ~wr_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // postscaler
  // counts raw matches only; its clear shares the prescaler's cause

  wire post_tick; // postscaled match event
  wire [3:0] post_cnt; // postscaler count, seen by checks only

  scaler_counter postscaler_i (
    .mclk(mclk),
    .resetn(resetn),
    .clear(scaler_clear),
    .step(match_pulse_reg),
    .limit(postscale_limit),
    .done(post_tick),
    .cnt(post_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flag and interrupt

  // a new event in the same cycle as a clear write keeps the flag set
  always_comb
  begin
    match_flag_next = match_flag_reg;
    if (wr_flags && reg_wdata[MATCH_BIT])
      match_flag_next = 1'b0;
    if (post_tick)
      match_flag_next = 1'b1;
  end

  // flag, control, enable and period registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      match_flag_reg <= 1'b0;
      match_irq_enable_reg <= 1'b0;
      timer_control_reg <= TIMER_CONTROL_RESET;
      period_value_reg <= PERIOD_VALUE_RESET;
    end
    else
    begin
      match_flag_reg <= match_flag_next;
      if (wr_enables)
        match_irq_enable_reg <= reg_wdata[MATCH_BIT];
      if (wr_control)
        timer_control_reg <= reg_wdata[6:0];
      if (wr_period)
        period_value_reg <= reg_wdata;
    end
  end

  // level interrupt, no latching beyond the flag itself
  assign irq = match_flag_reg & match_irq_enable_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read path
  // the mux decodes the same address that qualifies the read strobe

  // unmapped addresses and unused bits read as zero
  wire [7:0] rd_mux =
    sel_flags ? {6'h00, match_flag_reg, 1'b0} :
    sel_count ? timer_count_reg :
    sel_control ? {1'b0, timer_control_reg} :
    sel_enables ? {6'h00, match_irq_enable_reg, 1'b0} :
    sel_period ? period_value_reg :
    8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata_reg <= 8'h00;
    else
      reg_rdata_reg <= reg_rd ? rd_mux : 8'h00;
  end

  assign reg_rdata = reg_rdata_reg;
  assign timer_count_out = timer_count_reg;
  assign match_pulse = match_pulse_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // all checks sit idle while reset is low

  // increment at the period value, no load
  sequence wrap_cause_s;
    count_wrap && !wr_count;
  endsequence

  // the count is back at zero and the raw match is out
  sequence wrap_effect_s;
    (timer_count_reg == 8'h00) && match_pulse_reg;
  endsequence

  // raw match lasts exactly one cycle unless the next wrap follows at once
  sequence pulse_drop_s;
    match_pulse_reg ##1 (!match_pulse_reg || (timer_count_reg == 8'h00));
  endsequence

  wrap_to_zero_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    wrap_cause_s |=> wrap_effect_s)
    else $error("count did not wrap to zero on period match");

  count_step_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    pre_tick && !count_at_period && !wr_count
    |=> timer_count_reg == 8'($past(timer_count_reg) + 8'h01))
    else $error("count did not advance by one on a prescaler tick");

  stopped_hold_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    (!timer_run && !reg_wr) [*2] |=> $stable(timer_count_reg))
    else $error("count moved while the timer was stopped");

  prescale_div_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    pre_tick |-> (prescale_select[1] ? pre_cnt == 4'hF :
      prescale_select[0] ? pre_cnt == 4'h3 : pre_cnt == 4'h0))
    else $error("prescaler ticked at the wrong terminal count");

  scaler_clear_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    scaler_clear |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scalers not cleared by a count or control write");

  control_keep_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_control && !pre_tick |=> $stable(timer_count_reg))
    else $error("control write disturbed the count");

  count_load_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_count |=> timer_count_reg == $past(reg_wdata))
    else $error("count write not taken");

  period_load_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_period |=> period_value_reg == $past(reg_wdata))
    else $error("period write not taken");

  post_ratio_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    post_tick |-> post_cnt == postscale_select && match_pulse_reg)
    else $error("postscaler fired at the wrong ratio");

  flag_set_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    post_tick |=> match_flag_reg ##1 (match_flag_reg || $past(wr_flags)))
    else $error("postscaled match did not latch the flag");

  irq_gate_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    post_tick && match_irq_enable_reg && !wr_enables |=> irq)
    else $error("interrupt not raised for an enabled match");

  raw_pulse_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    wrap_cause_s |=> pulse_drop_s)
    else $error("raw match pulse malformed");

  bit7_zero_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    reg_rd && sel_control |=> reg_rdata[7] == 1'b0)
    else $error("control bit 7 did not read as zero");

  // software writes a one to the match bit, with no event beside it
  sequence flag_clear_s;
    wr_flags && reg_wdata[MATCH_BIT] && !post_tick;
  endsequence

  // a clear with no event beside it drops the flag
  flag_clear_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    flag_clear_s |=> !match_flag_reg)
    else $error("match flag not cleared by a one written to it");

  // the flag is sticky until software clears it
  flag_hold_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    match_flag_reg && !(wr_flags && reg_wdata[MATCH_BIT]) |=> match_flag_reg)
    else $error("match flag dropped without a clear");

  // only a postscaled match may raise the flag
  flag_source_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !match_flag_reg && !post_tick |=> !match_flag_reg)
    else $error("match flag rose without a postscaled match");

  // read data carry the count of the strobe cycle
  count_read_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    reg_rd && sel_count |=> reg_rdata == $past(timer_count_reg))
    else $error("count read returned the wrong value");

  // read data carry the period of the strobe cycle
  period_read_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    reg_rd && sel_period |=> reg_rdata == $past(period_value_reg))
    else $error("period read returned the wrong value");

  // bit 7 is dropped, bits 6:0 land as written
  control_load_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_control |=> timer_control_reg == 7'($past(reg_wdata)))
    else $error("control write not taken");

  // the raw match only ever shows beside a zero count
  pulse_at_zero_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    match_pulse_reg |-> timer_count_reg == COUNT_WRAP_VALUE)
    else $error("raw match seen with a nonzero count");

  // a stopped timer sends no match downstream
  stopped_quiet_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !timer_run |=> !match_pulse_reg)
    else $error("raw match while the timer was stopped");

  // the postscaler moves only on a raw match or a clear
  post_idle_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    !match_pulse_reg && !scaler_clear |=> $stable(post_cnt))
    else $error("postscaler moved without a raw match");

endmodule : period_timer

/* File: tb/match_watch.sv */
// stand-in for the compare unit and serial port on the match side
// assumes match_pulse is one cycle wide, registered on mclk
`timescale 1ns/1ps
module match_watch
  import period_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] timer_count_out,
  input wire logic match_pulse,
  output logic [7:0] top_seen
);
  logic [7:0] prev_reg; // count of the cycle before
  //////////////////////////////////////////////////////////////////////////
  // keep the count seen just before each wrap, as a pwm period would
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_reg <= 8'h00;
      top_seen <= 8'h00;
    end
    else
    begin
      prev_reg <= timer_count_out;
      if (match_pulse)
        top_seen <= prev_reg;
    end
  end
endmodule : match_watch

/* File: tb/tb_top.sv */
// register-level bench for the period timer
// assumes mclk is 40 MHz and the register port answers with no wait
`timescale 1ns/1ps
module tb_top;
  import period_timer_pkg::*;
  logic mclk, resetn, reg_wr, reg_rd, irq, match_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, timer_count_out, top_seen, d, e;
  int err_total, compares, cyc, n, n1;

  period_timer dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .timer_count_out(timer_count_out), .match_pulse(match_pulse));
  match_watch far_end (.mclk(mclk), .resetn(resetn), .timer_count_out(timer_count_out),
    .match_pulse(match_pulse), .top_seen(top_seen));

  //////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling far above the eleven hundred or so cycles needed
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_total++;
      results();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare, report, close
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////////
  // bus cycles: one-cycle strobes, read data in the following cycle only
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask : rchk
  // cycles up to the next raw match, bounded
  task wait_match(output int k);
    k = 0;
    do
    begin
      @(posedge mclk);
      #1 k++;
    end
    while (match_pulse !== 1'b1 && k < 500);
  endtask : wait_match
  // irq is a level, give it two edges to settle
  task chk_irq(input logic exp);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq}, {7'h00, exp});
  endtask : chk_irq

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    // reset values, and an unmapped place reads zero
    rchk(PERIOD_VALUE_ADDR, 8'hFF);
    rchk(TIMER_CONTROL_ADDR, 8'h00);
    rchk(TIMER_COUNT_ADDR, 8'h00);
    rchk(PERIPHERAL_FLAGS_ADDR, 8'h00);
    rchk(PERIPHERAL_ENABLES_ADDR, 8'h00);
    rchk(8'h20, 8'h00);
    wr(TIMER_CONTROL_ADDR, 8'hFB);
    rchk(TIMER_CONTROL_ADDR, 8'h7B);
    $display("test reset_values done");
    // every prescale code, period 3: wrap every ratio*4 cycles
    wr(PERIOD_VALUE_ADDR, 8'h03);
    rchk(PERIOD_VALUE_ADDR, 8'h03);
    wr(PERIPHERAL_ENABLES_ADDR, 8'h02);
    for (int s = 0; s < 4; s++)
    begin
      wr(TIMER_CONTROL_ADDR, 8'h04 | 8'(s));
      wait_match(n);
      wait_match(n);
      chk(8'(n), 8'((s == 0 ? 1 : (s == 1 ? 4 : 16)) * 4));
      chk(top_seen, 8'h03);
    end
    $display("test prescale done");
    // postscale 1:3 from a clean start
    wr(TIMER_CONTROL_ADDR, 8'h10);
    wr(TIMER_COUNT_ADDR, 8'h00);
    wr(PERIPHERAL_FLAGS_ADDR, 8'h02);
    wr(TIMER_CONTROL_ADDR, 8'h14);
    wait_match(n);
    wait_match(n);
    rchk(PERIPHERAL_FLAGS_ADDR, 8'h00);
    wait_match(n);
    rchk(PERIPHERAL_FLAGS_ADDR, 8'h02);
    wr(TIMER_CONTROL_ADDR, 8'h00);
    chk_irq(1'b1);
    wr(PERIPHERAL_ENABLES_ADDR, 8'h00);
    chk_irq(1'b0);
    wr(PERIPHERAL_ENABLES_ADDR, 8'h02);
    chk_irq(1'b1);
    wr(PERIPHERAL_FLAGS_ADDR, 8'h02);
    chk_irq(1'b0);
    rchk(PERIPHERAL_FLAGS_ADDR, 8'h00);
    $display("test postscale_irq done");
    // stopped count holds; control write keeps the count
    rd(TIMER_COUNT_ADDR, d);
    repeat (20) @(posedge mclk);
    rd(TIMER_COUNT_ADDR, e);
    chk(e, d);
    wr(TIMER_COUNT_ADDR, 8'h07);
    wr(TIMER_CONTROL_ADDR, 8'h18);
    rchk(TIMER_COUNT_ADDR, 8'h07);
    $display("test stop_hold done");
    // count write clears the prescaler; only the write 11 cycles after a match is checked
    wr(TIMER_CONTROL_ADDR, 8'h06);
    for (int p = 0; p < 2; p++)
    begin
      wait_match(n);
      repeat (5 + 6 * p) @(posedge mclk);
      wr(TIMER_COUNT_ADDR, 8'h00);
      n1 = n;
      wait_match(n);
      if (p == 1)
        chk(8'(n), 8'(n1));
    end
    $display("test scaler_clear done");
    // reset in mid-run
    wr(TIMER_CONTROL_ADDR, 8'h04);
    repeat (3) @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1 chk(timer_count_out, 8'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    rchk(TIMER_COUNT_ADDR, 8'h00);
    rchk(PERIOD_VALUE_ADDR, 8'hFF);
    rchk(TIMER_CONTROL_ADDR, 8'h00);
    $display("test mid_reset done");
    results();
  end
endmodule : tb_top
